/* hdl/swdt_pkg.sv */
// Constants, register map and types of the software watchdog timer.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package swdt_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned MAIN_DIV       = 16;
  localparam int unsigned PRESCALE       = 256;
  localparam int unsigned PULSE_CYCLES   = 16;
  localparam int unsigned STEP_CYCLES    = MAIN_DIV * PRESCALE;
  localparam int unsigned EFF_PRESCALE   = 2 * PRESCALE;
  localparam int unsigned MAX_STEPS      = 32767;
  localparam int unsigned PULSE_W        = $clog2(PULSE_CYCLES);
  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(PULSE_CYCLES - 1);

  // Bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_REFERENCE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_COUNT     = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 4'h8;

  // Reference register fields
  localparam int unsigned REF_W      = 16;
  localparam int unsigned REF_EN_BIT = 0;
  localparam logic [REF_W-1:0] REF_RESET = 16'hffff;
  localparam logic [REF_W-1:0] CNT_RESET = 16'h0000;

  // Control register fields
  localparam int unsigned CTL_PB7_BIT    = 0;
  localparam int unsigned CTL_HOLD_BIT   = 8;
  localparam int unsigned CTL_DRIVE_BIT  = 9;
  localparam logic        CTL_PB7_RESET  = 1'b1;

  // Byte lanes
  localparam int unsigned LANE_LO = 0;
  localparam int unsigned LANE_HI = 1;

  // Bus answer phase, Gray order idle -> answer
  typedef enum logic {
    SWDT_BUS_IDLE = 1'b0,
    SWDT_BUS_ANS  = 1'b1
  } swdt_bus_t;

endpackage

/* hdl/swdt_prescale.sv */
// Fixed prescaler chain of the watchdog: main clock / MAIN_DIV, then / PRESCALE.
// Assumes clk_i is the main clock; clear_i restarts the chain.
`timescale 1ns/10ps
`default_nettype none
module swdt_prescale
  import swdt_pkg::*;
#(
  parameter int unsigned FIRST_DIV  = MAIN_DIV,
  parameter int unsigned SECOND_DIV = PRESCALE
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic run_i,
  input  wire logic clear_i,
  // Count step
  output logic      tick_o
);

  localparam int unsigned FW = (FIRST_DIV > 1) ? $clog2(FIRST_DIV) : 1;
  localparam int unsigned SW = (SECOND_DIV > 1) ? $clog2(SECOND_DIV) : 1;

  if (FIRST_DIV < 2 || SECOND_DIV < 2) begin : g_bad
    $error("swdt_prescale: both dividers must be at least 2");
  end

  typedef struct packed {
    logic [FW-1:0] first;
    logic [SW-1:0] second;
    logic          tick;
  } swdt_pre_t;

  swdt_pre_t s;
  swdt_pre_t next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (clear_i || !run_i) begin
      next_s.first  = '0;
      next_s.second = '0;
    end else if (s.first == FW'(FIRST_DIV - 1)) begin
      next_s.first = '0;
      if (s.second == SW'(SECOND_DIV - 1)) begin
        next_s.second = '0;
        next_s.tick   = 1'b1;
      end else begin
        next_s.second = s.second + SW'(1);
      end
    end else begin
      next_s.first = s.first + FW'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

endmodule
`default_nettype wire

/* hdl/swdt_top.sv */
// Software watchdog timer with an Avalon-MM register slave.
// Assumes clk_i is the main clock and that an external pull-up
// holds the open-drain watchdog line high when nobody drives it.
//
// How it works
// - Count to 32767 steps of 8192 clocks
// - Prescaler input is main clock over 16
// - Fixed 256 prescaler clocks 16-bit counter
// - Compare ignores counter LSB, effective 512
// - Match restarts the count at once
// - Match drives watchdog output 16 clocks
// - Match also pulses interrupt request out
// - Counter readable any time; a write clears it
// - Prescaler has no software access
// - Read-write reference with enable bit
// - 8-bit mode high write holds compare
// - Reset sets reference to all ones
// - Reset enables counter, selects port B7
// - Watchdog output is open-drain
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module swdt_top
  import swdt_pkg::*;
#(
  parameter int unsigned FIRST_DIV  = MAIN_DIV,
  parameter int unsigned SECOND_DIV = PRESCALE
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  input  wire logic [BE_W-1:0]   avs_byteenable_i,
  output logic [DATA_W-1:0]      avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Bus width strap, low selects 8-bit bus mode
  input  wire logic              bus_width_select_i,
  // Open-drain watchdog line
  input  wire logic              watchdog_out_n_i,
  output logic                   watchdog_out_n_o,
  output logic                   watchdog_out_n_oe_o,
  // Pin function select for port B bit 7
  output logic                   port_b_bit7_select_o,
  // Interrupt request towards the interrupt controller
  output logic                   irq_o
);

  localparam int unsigned REF_LANES = REF_W / 8;

  // Elaboration checks
  if (REF_W != 16) begin : g_bad_width
    $error("swdt_top: reference width must be 16");
  end
  if (FIRST_DIV < 2 || SECOND_DIV < 2) begin : g_bad_div
    $error("swdt_top: both dividers must be at least 2");
  end
  if (REF_EN_BIT != 0) begin : g_bad_enable
    $error("swdt_top: the enable bit must be the reference LSB");
  end
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > (1 << PULSE_W)) begin : g_bad_pulse
    $error("swdt_top: pulse counter too narrow for the pulse length");
  end
  if (DATA_W < REF_W || BE_W < REF_LANES) begin : g_bad_bus
    $error("swdt_top: bus word narrower than the reference register");
  end
  if (LANE_LO >= REF_LANES || LANE_HI >= REF_LANES) begin : g_bad_lane
    $error("swdt_top: reference lanes outside the register");
  end
  if (CTL_DRIVE_BIT >= DATA_W || CTL_HOLD_BIT >= DATA_W || CTL_PB7_BIT >= DATA_W) begin : g_bad_ctl
    $error("swdt_top: control fields fall outside the bus word");
  end

  typedef struct packed {
    logic [REF_W-1:0]  reference;
    logic [REF_W-1:0]  count;
    logic              hold;
    logic              pb7_sel;
    logic              drive;
    logic [PULSE_W-1:0] pulse_left;
    logic              irq;
    swdt_bus_t         phase;
    logic [DATA_W-1:0] rdata;
  } swdt_state_t;

  // Power-on contents: timer enabled with the longest timeout
  localparam swdt_state_t S_RESET = '{
    reference:  REF_RESET,
    count:      CNT_RESET,
    hold:       1'b0,
    pb7_sel:    CTL_PB7_RESET,
    drive:      1'b0,
    pulse_left: {PULSE_W{1'b0}},
    irq:        1'b0,
    phase:      SWDT_BUS_IDLE,
    rdata:      {DATA_W{1'b0}}
  };

  swdt_state_t s;
  swdt_state_t next_s;

  logic                 tick;
  logic                 run;
  logic                 req;
  logic                 take;
  logic                 sel_ref;
  logic                 sel_cnt;
  logic                 sel_ctl;
  logic                 wr_ref;
  logic                 wr_cnt;
  logic                 wr_ctl;
  logic [REF_W-1:0]     count_inc;
  logic                 match;
  logic                 pulse_done;
  logic [REF_LANES-1:0] lane_we;
  logic [REF_W-1:0]     ref_merged;

  // The prescaler is internal only; nothing maps it onto the bus
  swdt_prescale #(
    .FIRST_DIV  (FIRST_DIV),
    .SECOND_DIV (SECOND_DIV)
  ) u_prescale (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (run),
    .clear_i (wr_cnt),
    .tick_o  (tick)
  );

  // One wait cycle, then the answer; a write acts on the answer edge
  assign req    = avs_read_i | avs_write_i;
  assign take   = req && (s.phase == SWDT_BUS_ANS);
  assign sel_ref = (avs_address_i == OFS_REFERENCE);
  assign sel_cnt = (avs_address_i == OFS_COUNT);
  assign sel_ctl = (avs_address_i == OFS_CONTROL);
  assign wr_ref  = take && avs_write_i && sel_ref;
  assign wr_cnt  = take && avs_write_i && sel_cnt;
  assign wr_ctl  = take && avs_write_i && sel_ctl;

  assign run       = s.reference[REF_EN_BIT];
  assign count_inc  = s.count + REF_W'(1);
  assign pulse_done = (s.pulse_left == '0);

  // Each byte lane of the reference is written on its own
  for (genvar g = 0; g < REF_LANES; g++) begin : g_lane
    assign lane_we[g]           = wr_ref && avs_byteenable_i[g];
    assign ref_merged[8*g +: 8] = lane_we[g] ? avs_writedata_i[8*g +: 8] : s.reference[8*g +: 8];
  end

  // LSB of the count takes no part; the reference LSB is the enable bit
  assign match = run && tick && !s.hold && !wr_cnt &&
                 (count_inc[REF_W-1:1] == s.reference[REF_W-1:1]);

  always_comb begin
    next_s     = s;
    next_s.irq = 1'b0;

    // Counter
    if (wr_cnt) begin
      next_s.count = CNT_RESET;
    end else if (match) begin
      next_s.count = CNT_RESET;
    end else if (run && tick) begin
      next_s.count = count_inc;
    end

    // Timeout events
    if (match) begin
      next_s.drive      = 1'b1;
      next_s.pulse_left = PULSE_LAST;
      next_s.irq        = 1'b1;
    end else if (s.drive) begin
      if (pulse_done) begin
        next_s.drive = 1'b0;
      end else begin
        next_s.pulse_left = s.pulse_left - PULSE_W'(1);
      end
    end

    // Reference register, byte lanes
    if (wr_ref) begin
      next_s.reference = ref_merged;
      if (lane_we[LANE_LO]) begin
        next_s.hold = 1'b0;
      end else if (lane_we[LANE_HI] && !bus_width_select_i) begin
        next_s.hold = 1'b1;
      end
    end

    // Control register
    if (wr_ctl && avs_byteenable_i[LANE_LO]) begin
      next_s.pb7_sel = avs_writedata_i[CTL_PB7_BIT];
    end

    // Bus answer phase and read data
    case (s.phase)
      SWDT_BUS_IDLE: begin
        if (req) begin
          next_s.phase = SWDT_BUS_ANS;
          next_s.rdata = '0;
          if (avs_read_i) begin
            case (avs_address_i)
              OFS_REFERENCE: begin
                next_s.rdata[REF_W-1:0] = s.reference;
              end
              OFS_COUNT: begin
                next_s.rdata[REF_W-1:0] = s.count;
              end
              OFS_CONTROL: begin
                next_s.rdata[CTL_PB7_BIT]   = s.pb7_sel;
                next_s.rdata[CTL_HOLD_BIT]  = s.hold;
                next_s.rdata[CTL_DRIVE_BIT] = s.drive;
              end
              default: begin
                next_s.rdata = '0;
              end
            endcase
          end
        end
      end
      SWDT_BUS_ANS: begin
        next_s.phase = SWDT_BUS_IDLE;
      end
      default: begin
        next_s.phase = SWDT_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= S_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Only ever pulls low; the line level is read back for nothing here
  assign watchdog_out_n_o     = 1'b0;
  assign watchdog_out_n_oe_o  = s.drive;
  assign port_b_bit7_select_o = s.pb7_sel;
  assign irq_o                = s.irq;
  assign avs_readdata_o       = s.rdata;
  assign avs_waitrequest_o    = req && (s.phase == SWDT_BUS_IDLE);

  logic unused_line;
  assign unused_line = watchdog_out_n_i;

endmodule
`default_nettype wire

/* test/swdt_far_end.sv */
// Far side of the watchdog: pulled-up line plus interrupt and reset inputs.
// Assumes the design splits the open-drain pin into drive and enable.
`timescale 1ns/10ps
`default_nettype none
module swdt_far_end (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Watchdog line and request
  input  wire logic   oe_i,
  input  wire logic   drv_i,
  input  wire logic   irq_i,
  // Line level and event counts
  output logic        line_o,
  output logic [15:0] irqs_o,
  output logic [15:0] lows_o
);
  assign line_o = oe_i ? drv_i : 1'b1;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irqs_o <= 16'h0000;
      lows_o <= 16'h0000;
    end else begin
      irqs_o <= irqs_o + {15'h0000, irq_i};
      lows_o <= lows_o + {15'h0000, !line_o};
    end
  end
endmodule
`default_nettype wire

/* test/swdt_props.sv */
// Port-level assertions for the software watchdog timer.
// Bound into every swdt_top instance; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module swdt_props
  import swdt_pkg::*;
#(
  parameter int unsigned FIRST_DIV  = MAIN_DIV,
  parameter int unsigned SECOND_DIV = PRESCALE
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Bus
  input  wire logic              avs_read_i,
  input  wire logic [DATA_W-1:0] avs_readdata_o,
  input  wire logic              avs_waitrequest_o,
  // Pins
  input  wire logic              watchdog_out_n_o,
  input  wire logic              watchdog_out_n_oe_o,
  input  wire logic              port_b_bit7_select_o,
  input  wire logic              irq_o
);
  localparam int unsigned STEP = FIRST_DIV * SECOND_DIV;
  logic [4:0]  low_run;
  logic [31:0] gap;
  // Length of the current low pulse and clocks since the last timeout
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_run <= 5'h0;
      gap     <= 32'h0000_0000;
    end else begin
      low_run <= watchdog_out_n_oe_o ? low_run + 5'h1 : 5'h0;
      gap     <= irq_o ? 32'h0000_0001 : (gap == 32'h0000_0000 ? gap : gap + 32'h0000_0001);
    end
  end
  property p_open_drain;
    @(posedge clk_i) disable iff (rst_i) watchdog_out_n_oe_o |-> !watchdog_out_n_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_pulse_len;
    @(posedge clk_i) disable iff (rst_i) $fell(watchdog_out_n_oe_o) |-> low_run == 5'h10;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
  property p_irq_pulse;
    @(posedge clk_i) disable iff (rst_i) irq_o |=> !irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one clock");
  property p_irq_rose;
    @(posedge clk_i) disable iff (rst_i) irq_o |-> $rose(watchdog_out_n_oe_o);
  endproperty
  a_irq_rose: assert property (p_irq_rose) else $error("irq without pulse start");
  property p_rose_irq;
    @(posedge clk_i) disable iff (rst_i) $rose(watchdog_out_n_oe_o) |-> irq_o;
  endproperty
  a_rose_irq: assert property (p_rose_irq) else $error("pulse without irq");
  property p_gap;
    @(posedge clk_i) disable iff (rst_i) irq_o && gap != 32'h0000_0000 |-> gap >= STEP;
  endproperty
  a_gap: assert property (p_gap) else $error("timeouts closer than one step");
  property p_read_width;
    @(posedge clk_i) disable iff (rst_i) avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000;
  endproperty
  a_read_width: assert property (p_read_width) else $error("upper read bits set");
  property p_reset_state;
    @(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> port_b_bit7_select_o && !watchdog_out_n_oe_o;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("pin state after reset");
endmodule
bind swdt_top swdt_props #(.FIRST_DIV(FIRST_DIV), .SECOND_DIV(SECOND_DIV)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .watchdog_out_n_o(watchdog_out_n_o),
  .watchdog_out_n_oe_o(watchdog_out_n_oe_o), .port_b_bit7_select_o(port_b_bit7_select_o), .irq_o(irq_o));
`default_nettype wire

/* test/swdt_top_tb.sv */
// Self-checking bench for swdt_top with a four-clock count step.
// Assumes swdt_props is bound and swdt_far_end models the far side.
`timescale 1ns/10ps
`default_nettype none
module swdt_top_tb;
  import swdt_pkg::*;
  localparam int unsigned STEP = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, bws = 1'b1;
  logic [3:0]  addr = 4'h0, be = 4'hf;
  logic [31:0] wd = 32'h0000_0000, rdata, q;
  logic        wreq, drv, oe, pb7, irq, line;
  logic [15:0] irqs, lows, base, lbase;
  int          miscompares = 0, tests_run = 0, n;
  swdt_top #(.FIRST_DIV(2), .SECOND_DIV(2)) uut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .bus_width_select_i(bws), .watchdog_out_n_i(line), .watchdog_out_n_o(drv),
    .watchdog_out_n_oe_o(oe), .port_b_bit7_select_o(pb7), .irq_o(irq));
  swdt_far_end far (.clk_i(clk_i), .rst_i(rst_i), .oe_i(oe), .drv_i(drv), .irq_i(irq), .line_o(line),
    .irqs_o(irqs), .lows_o(lows));
  always #20 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One Avalon transfer; read data lands in q at the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    @(posedge clk_i);
    while (wreq !== 1'b0) begin
      @(posedge clk_i);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wait_irq();
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 200);
  endtask
  task automatic t_reset();
    bus(1'b0, OFS_REFERENCE, 32'h0000_0000, 4'hf);
    chk(q, 32'h0000_ffff, "reference reset");
    bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hf);
    chk(q & 32'h0000_0001, 32'h0000_0001, "pin select");
    bus(1'b0, 4'hc, 32'h0000_0000, 4'hf);
    chk(q, 32'h0000_0000, "unmapped read");
    chk(pb7, 1'b1, "pin select output");
    // Two count steps have passed since reset release when this read is taken
    bus(1'b0, OFS_COUNT, 32'h0000_0000, 4'hf);
    chk(q, 32'h0000_0002, "count after reset");
  endtask
  task automatic t_timeout();
    bus(1'b1, OFS_COUNT, 32'h0000_ffff, 4'hf);
    bus(1'b1, OFS_REFERENCE, 32'h0000_0007, 4'h3);
    bus(1'b1, OFS_COUNT, 32'h0000_ffff, 4'hf);
    base = irqs;
    lbase = lows;
    wait_irq();
    // The interrupt is registered one clock after the sixth count step
    chk(n, 6 * STEP + 1, "first timeout");
    wait_irq();
    chk(n, 6 * STEP, "restart");
    repeat (20) @(posedge clk_i);
    chk(irqs - base, 2, "irq count");
    chk(lows - lbase, 2 * PULSE_CYCLES, "low clocks");
    bus(1'b1, OFS_COUNT, 32'h0000_ffff, 4'hf);
    bus(1'b0, OFS_COUNT, 32'h0000_0000, 4'hf);
    chk(q, 32'h0000_0000, "count clear");
  endtask
  task automatic t_kick();
    base = irqs;
    repeat (5) begin
      repeat (12) @(posedge clk_i);
      bus(1'b1, OFS_COUNT, 32'h0000_0000, 4'h1);
    end
    chk(irqs, base, "kicked timeout");
  endtask
  task automatic t_disable();
    logic [31:0] first;
    bus(1'b1, OFS_REFERENCE, 32'h0000_0006, 4'h3);
    bus(1'b0, OFS_REFERENCE, 32'h0000_0000, 4'hf);
    chk(q, 32'h0000_0006, "reference readback");
    bus(1'b0, OFS_COUNT, 32'h0000_0000, 4'hf);
    first = q;
    base = irqs;
    repeat (40) @(posedge clk_i);
    bus(1'b0, OFS_COUNT, 32'h0000_0000, 4'hf);
    chk(q, first, "frozen count");
    chk(irqs, base, "disabled timeout");
  endtask
  task automatic t_hold();
    bws <= 1'b0;
    bus(1'b1, OFS_COUNT, 32'h0000_0000, 4'hf);
    bus(1'b1, OFS_REFERENCE, 32'h0000_0007, 4'h3);
    bus(1'b1, OFS_REFERENCE, 32'h0000_0000, 4'h2);
    bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hf);
    chk(q[CTL_HOLD_BIT], 1'b1, "hold status");
    base = irqs;
    repeat (40) @(posedge clk_i);
    chk(irqs, base, "held compare");
    bus(1'b1, OFS_REFERENCE, 32'h0000_0007, 4'h1);
    bus(1'b1, OFS_COUNT, 32'h0000_0000, 4'hf);
    wait_irq();
    chk(n, 6 * STEP + 1, "released compare");
    @(posedge clk_i);
    bws <= 1'b1;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_timeout();
    t_kick();
    t_disable();
    t_hold();
    wrap_up();
  end
endmodule
`default_nettype wire
